// ==== rtl/adc_multidevice_serial.v ====
// Serial host port of the converter: shifter, register file, power-down control.
`timescale 1ns/1ps
`include "adc_chain_defines.vh"
module adc_multidevice_serial #(
	parameter USR_WIDTH = 22,
	parameter RESULT_WIDTH = 18
) (
	// Clock and reset.
	input wire clk_i,
	input wire srst_i,
	// Host pins.
	input wire conversion_start_i,
	input wire cs_n_i,
	input wire sclk_i,
	input wire sdi_i,
	output reg serial_out_lane0_o,
	output reg serial_out_lane0_oe_o,
	// Converter core.
	input wire [RESULT_WIDTH-1:0] conv_data_i,
	output reg conv_sample_o,
	// Power control.
	output reg converter_power_down_o,
	output reg refbuf_power_down_o,
	output reg converter_powerup_start_o,
	output reg refbuf_powerup_start_o
);

wire [`PIN_COUNT-1:0] pin_level;
wire [`PIN_COUNT-1:0] pin_rise;
wire [`PIN_COUNT-1:0] pin_fall;
wire [USR_WIDTH-1:0] usr_word;

reg [7:0] cfg_reg [0:`REG_COUNT-1];
reg [RESULT_WIDTH-1:0] result_reg;
reg [7:0] readback_reg;
reg read_pending_reg;
reg [4:0] capture_count_reg;
reg [4:0] capture_count_next;

reg usr_load;
reg [USR_WIDTH-1:0] usr_load_data;
reg leading_edge;
reg trailing_edge;
reg capture_edge;
reg launch_edge;
reg frame_end;
reg frame_full;
reg [3:0] cmd;
reg [3:0] wr_index;
reg [7:0] wr_data;
reg [7:0] pd_new;
reg cpol;
reg cpha;
integer k;

// Maps a register byte address onto its storage index.
function [3:0] reg_index;
	input [`ADDR_WIDTH-1:0] addr;
	begin
		case (addr)
			`ADDR_POWER_DOWN_CONTROL: reg_index = `IDX_POWER_DOWN_CONTROL;
			`ADDR_INPUT_PROTOCOL_SELECT: reg_index = `IDX_INPUT_PROTOCOL_SELECT;
			`ADDR_OUTPUT_PROTOCOL_SELECT: reg_index = `IDX_OUTPUT_PROTOCOL_SELECT;
			`ADDR_OUTPUT_WORD_CONFIG: reg_index = `IDX_OUTPUT_WORD_CONFIG;
			`ADDR_PATTERN_LOW_BYTE: reg_index = `IDX_PATTERN_LOW_BYTE;
			`ADDR_PATTERN_MIDDLE_BYTE: reg_index = `IDX_PATTERN_MIDDLE_BYTE;
			`ADDR_PATTERN_HIGH_NIBBLE: reg_index = `IDX_PATTERN_HIGH_NIBBLE;
			`ADDR_OFFSET_CALIBRATION: reg_index = `IDX_OFFSET_CALIBRATION;
			`ADDR_REFERENCE_MARGIN: reg_index = `IDX_REFERENCE_MARGIN;
			default: reg_index = `IDX_NONE;
		endcase
	end
endfunction

// Writable bits of each register; reserved bits stay zero.
function [7:0] reg_mask;
	input [3:0] index;
	begin
		case (index)
			`IDX_POWER_DOWN_CONTROL: reg_mask = `MASK_POWER_DOWN_CONTROL;
			`IDX_INPUT_PROTOCOL_SELECT: reg_mask = `MASK_INPUT_PROTOCOL_SELECT;
			`IDX_OUTPUT_PROTOCOL_SELECT: reg_mask = `MASK_OUTPUT_PROTOCOL_SELECT;
			`IDX_OUTPUT_WORD_CONFIG: reg_mask = `MASK_OUTPUT_WORD_CONFIG;
			`IDX_NONE: reg_mask = 8'h00;
			default: reg_mask = `MASK_FULL_BYTE;
		endcase
	end
endfunction

pin_sync #(
	.WIDTH(`PIN_COUNT),
	.INIT(`PIN_INIT)
) u_pin_sync (
	.clk_i(clk_i),
	.srst_i(srst_i),
	.pin_i({sdi_i, sclk_i, cs_n_i, conversion_start_i}),
	.level_o(pin_level),
	.rise_o(pin_rise),
	.fall_o(pin_fall)
);

usr_shifter #(
	.WIDTH(USR_WIDTH)
) u_usr ( // RULE_02
	.clk_i(clk_i),
	.srst_i(srst_i),
	.load_i(usr_load),
	.load_data_i(usr_load_data),
	.shift_i(capture_edge),
	.bit_i(pin_level[`PIN_SDI]),
	.word_o(usr_word)
);

// Clock polarity and phase come from the input protocol field.
always @*
begin
	cpol = cfg_reg[`IDX_INPUT_PROTOCOL_SELECT][`CPOL_BIT]; // RULE_21
	cpha = cfg_reg[`IDX_INPUT_PROTOCOL_SELECT][`CPHA_BIT]; // RULE_21
	leading_edge = cpol ? pin_fall[`PIN_SCLK] : pin_rise[`PIN_SCLK];
	trailing_edge = cpol ? pin_rise[`PIN_SCLK] : pin_fall[`PIN_SCLK];
	// Serial clock edges count only inside a frame, never on its opening cycle.
	capture_edge = ~pin_level[`PIN_CS_N] & ~pin_fall[`PIN_CS_N]
		& (cpha ? trailing_edge : leading_edge); // RULE_06
	launch_edge = ~pin_level[`PIN_CS_N] & ~pin_fall[`PIN_CS_N]
		& (cpha ? leading_edge : trailing_edge); // RULE_05
	frame_end = pin_rise[`PIN_CS_N];
end

// Frame start loads either a pending register readback or the latest result.
always @*
begin
	usr_load = pin_fall[`PIN_CS_N]; // RULE_04
	if (read_pending_reg)
		usr_load_data = {readback_reg, {(USR_WIDTH-8){1'b0}}};
	else
		usr_load_data = {result_reg, {(USR_WIDTH-RESULT_WIDTH){1'b0}}};
end

// Capture edges are counted so that a short frame is never decoded.
always @*
begin
	capture_count_next = capture_count_reg;
	if (pin_fall[`PIN_CS_N])
		capture_count_next = 5'h00;
	else if (capture_edge && capture_count_reg != USR_WIDTH[4:0])
		capture_count_next = capture_count_reg + 5'h01;
	frame_full = (capture_count_reg == USR_WIDTH[4:0]);
end

// Decode of the shifter contents at the end of a frame.
always @*
begin
	cmd = usr_word[`CMD_MSB:`CMD_LSB];
	wr_index = reg_index(usr_word[`ADDR_MSB:`ADDR_LSB]);
	wr_data = usr_word[`DATA_MSB:`DATA_LSB] & reg_mask(wr_index); // RULE_15
	pd_new = cfg_reg[`IDX_POWER_DOWN_CONTROL];
	if (frame_end && frame_full && cmd == `CMD_WRITE && wr_index == `IDX_POWER_DOWN_CONTROL)
		pd_new = wr_data;
end

always @(posedge clk_i)
begin
	if (srst_i)
	begin
		for (k = 0; k < `REG_COUNT; k = k + 1)
			cfg_reg[k] <= `REG_RESET;
		readback_reg <= 8'h00;
		read_pending_reg <= 1'b0;
		capture_count_reg <= 5'h00;
	end
	else
	begin
		capture_count_reg <= capture_count_next;
		if (pin_fall[`PIN_CS_N])
			read_pending_reg <= 1'b0;
		if (frame_end && frame_full) // RULE_07
		begin
			case (cmd)
				`CMD_WRITE:
				begin
					if (wr_index != `IDX_NONE)
						cfg_reg[wr_index] <= wr_data; // RULE_14
				end
				`CMD_READ:
				begin
					if (wr_index != `IDX_NONE)
						readback_reg <= cfg_reg[wr_index];
					else
						readback_reg <= 8'h00;
					read_pending_reg <= 1'b1;
				end
				default:
				begin
					read_pending_reg <= 1'b0;
				end
			endcase
		end
	end
end

// Conversion start: the core result is taken on the rising edge while powered.
always @(posedge clk_i)
begin
	if (srst_i)
	begin
		result_reg <= {RESULT_WIDTH{1'b0}};
		conv_sample_o <= 1'b0;
	end
	else
	begin
		conv_sample_o <= 1'b0;
		if (pin_rise[`PIN_CONVERSION_START] && !converter_power_down_o)
		begin
			result_reg <= conv_data_i; // RULE_03
			conv_sample_o <= 1'b1; // RULE_03
		end
	end
end

// Serial output lane: drives the shifter MSB only while selected.
always @(posedge clk_i)
begin
	if (srst_i)
	begin
		serial_out_lane0_o <= 1'b0;
		serial_out_lane0_oe_o <= 1'b0;
	end
	else
	begin
		serial_out_lane0_oe_o <= ~pin_level[`PIN_CS_N] & ~frame_end; // RULE_13
		if (usr_load)
			serial_out_lane0_o <= usr_load_data[USR_WIDTH-1];
		else if (launch_edge)
			serial_out_lane0_o <= usr_word[USR_WIDTH-1]; // RULE_05
	end
end

// Power states follow the register only at select rising.
always @(posedge clk_i)
begin
	if (srst_i)
	begin
		converter_power_down_o <= 1'b0;
		refbuf_power_down_o <= 1'b0;
		converter_powerup_start_o <= 1'b0;
		refbuf_powerup_start_o <= 1'b0;
	end
	else
	begin
		converter_powerup_start_o <= 1'b0;
		refbuf_powerup_start_o <= 1'b0;
		if (frame_end)
		begin
			converter_power_down_o <= pd_new[`PD_CONVERTER_BIT]; // RULE_16
			refbuf_power_down_o <= pd_new[`REFBUF_POWER_DOWN_BIT]; // RULE_19
			converter_powerup_start_o <= converter_power_down_o
				& ~pd_new[`PD_CONVERTER_BIT]; // RULE_17
			refbuf_powerup_start_o <= refbuf_power_down_o
				& ~pd_new[`REFBUF_POWER_DOWN_BIT]; // RULE_20
		end
	end
end

endmodule

// ==== rtl/adc_chain_defines.vh ====
// Constants for the multi-device serial host port of the converter.
//
// Contract
// RULE_01: Host programs identical, legacy-protocol configuration in chain.
// RULE_02: Output and input registers form one 22-bit shifter.
// RULE_03: Analog input sampled on conversion-start rising edge.
// RULE_04: Frame begins when select falls.
// RULE_05: Launch edge drives shifter MSB onto lane 0.
// RULE_06: Capture edge shifts serial input into LSB.
// RULE_07: Select rising decodes shifter and performs action.
// RULE_08: Host receives last device's word first.
// RULE_09: Optimal frame has 22 times N capture edges.
// RULE_10: Longer frames need host-aligned configuration bits.
// RULE_11: Host never sends fewer than 22 times N clocks.
// RULE_12: Star arrangement selects only one device at once.
// RULE_13: Deselected device releases its serial output.
// RULE_14: Nine byte-wide configuration registers at fixed addresses.
// RULE_15: Power-down bits 7..3 and 0 read zero.
// RULE_16: Converter power-down bit acts at select rising.
// RULE_17: Clearing converter bit starts power-up at select rising.
// RULE_18: Host waits converter power-up time before use.
// RULE_19: Buffer power-down bit acts at select rising.
// RULE_20: Clearing buffer bit starts power-up; host then waits.
// RULE_21: Input protocol field selects clock polarity and phase.
`ifndef ADC_CHAIN_DEFINES_VH
`define ADC_CHAIN_DEFINES_VH

`define USR_WIDTH 22
`define RESULT_WIDTH 18
`define ADDR_WIDTH 10

// Command word layout inside the shifter.
`define CMD_MSB 21
`define CMD_LSB 18
`define ADDR_MSB 17
`define ADDR_LSB 8
`define DATA_MSB 7
`define DATA_LSB 0
`define CMD_NOP 4'h0
`define CMD_WRITE 4'ha
`define CMD_READ 4'hc

// Register byte addresses.
`define ADDR_POWER_DOWN_CONTROL 10'h004
`define ADDR_INPUT_PROTOCOL_SELECT 10'h008
`define ADDR_OUTPUT_PROTOCOL_SELECT 10'h00c
`define ADDR_OUTPUT_WORD_CONFIG 10'h010
`define ADDR_PATTERN_LOW_BYTE 10'h014
`define ADDR_PATTERN_MIDDLE_BYTE 10'h015
`define ADDR_PATTERN_HIGH_NIBBLE 10'h016
`define ADDR_OFFSET_CALIBRATION 10'h020
`define ADDR_REFERENCE_MARGIN 10'h030

// Register indices in the storage array.
`define IDX_POWER_DOWN_CONTROL 4'h0
`define IDX_INPUT_PROTOCOL_SELECT 4'h1
`define IDX_OUTPUT_PROTOCOL_SELECT 4'h2
`define IDX_OUTPUT_WORD_CONFIG 4'h3
`define IDX_PATTERN_LOW_BYTE 4'h4
`define IDX_PATTERN_MIDDLE_BYTE 4'h5
`define IDX_PATTERN_HIGH_NIBBLE 4'h6
`define IDX_OFFSET_CALIBRATION 4'h7
`define IDX_REFERENCE_MARGIN 4'h8
`define IDX_NONE 4'hf
`define REG_COUNT 9

// Writable bit masks and reset values.
`define MASK_POWER_DOWN_CONTROL 8'h06
`define MASK_INPUT_PROTOCOL_SELECT 8'h03
`define MASK_OUTPUT_PROTOCOL_SELECT 8'hdf
`define MASK_OUTPUT_WORD_CONFIG 8'h0f
`define MASK_FULL_BYTE 8'hff
`define REG_RESET 8'h00

// Field positions.
`define PD_CONVERTER_BIT 1
`define REFBUF_POWER_DOWN_BIT 2
`define CPHA_BIT 0
`define CPOL_BIT 1

// Synchronised pin vector positions.
`define PIN_CONVERSION_START 0
`define PIN_CS_N 1
`define PIN_SCLK 2
`define PIN_SDI 3
`define PIN_COUNT 4
`define PIN_INIT 4'h2

`endif

// ==== rtl/pin_sync.v ====
// Three-stage pin synchroniser with agreement filter and edge pulses.
`timescale 1ns/1ps
module pin_sync #(
	parameter WIDTH = 4,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
	// Clock and reset.
	input wire clk_i,
	input wire srst_i,
	// Asynchronous pins.
	input wire [WIDTH-1:0] pin_i,
	// Filtered levels and one-cycle edge pulses.
	output reg [WIDTH-1:0] level_o,
	output reg [WIDTH-1:0] rise_o,
	output reg [WIDTH-1:0] fall_o
);

reg [WIDTH-1:0] s1_reg;
reg [WIDTH-1:0] s2_reg;
reg [WIDTH-1:0] s3_reg;
reg [WIDTH-1:0] level_next;
integer i;

// A change counts only once the second and third stages agree.
always @*
begin
	for (i = 0; i < WIDTH; i = i + 1)
	begin
		if (s2_reg[i] == s3_reg[i])
			level_next[i] = s2_reg[i];
		else
			level_next[i] = level_o[i];
	end
end

always @(posedge clk_i)
begin
	if (srst_i)
	begin
		s1_reg <= INIT;
		s2_reg <= INIT;
		s3_reg <= INIT;
		level_o <= INIT;
		rise_o <= {WIDTH{1'b0}};
		fall_o <= {WIDTH{1'b0}};
	end
	else
	begin
		s1_reg <= pin_i;
		s2_reg <= s1_reg;
		s3_reg <= s2_reg;
		level_o <= level_next;
		rise_o <= level_next & ~level_o;
		fall_o <= ~level_next & level_o;
	end
end

endmodule

// ==== rtl/usr_shifter.v ====
// Unified shift register: parallel load, serial shift in at the LSB.
`timescale 1ns/1ps
module usr_shifter #(
	parameter WIDTH = 22
) (
	// Clock and reset.
	input wire clk_i,
	input wire srst_i,
	// Parallel load.
	input wire load_i,
	input wire [WIDTH-1:0] load_data_i,
	// Serial shift.
	input wire shift_i,
	input wire bit_i,
	// Contents.
	output reg [WIDTH-1:0] word_o
);

always @(posedge clk_i)
begin
	if (srst_i)
		word_o <= {WIDTH{1'b0}};
	else if (load_i)
		word_o <= load_data_i;
	else if (shift_i)
		word_o <= {word_o[WIDTH-2:0], bit_i}; // RULE_06
end

endmodule

// ==== dv/adc_serial_props.sv ====
// Checker for the converter's serial host port.
`timescale 1ns/1ps
module adc_serial_props (
	// Clock and reset.
	input wire clk_i,
	input wire srst_i,
	// Host pins.
	input wire conversion_start_i,
	input wire cs_n_i,
	input wire sclk_i,
	// Outputs under watch.
	input wire serial_out_lane0_o,
	input wire serial_out_lane0_oe_o,
	input wire conv_sample_o,
	input wire converter_power_down_o,
	input wire refbuf_power_down_o,
	input wire converter_powerup_start_o,
	input wire refbuf_powerup_start_o
);
	reg [3:0] hi_cnt;
	reg [3:0] lo_cnt;
	// Cycles that select has held its present level, saturating.
	always @(posedge clk_i)
	begin
		hi_cnt <= (srst_i || !cs_n_i) ? 4'h0 : hi_cnt + {3'h0, hi_cnt != 4'hf};
		lo_cnt <= (srst_i || cs_n_i) ? 4'h0 : lo_cnt + {3'h0, lo_cnt != 4'hf};
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (srst_i);
	a_oe_released: assert property (hi_cnt > 4'h6 |-> !serial_out_lane0_oe_o)
		else $error("lane enabled while deselected");
	a_oe_driven: assert property (lo_cnt > 4'h6 |-> serial_out_lane0_oe_o)
		else $error("lane not enabled in frame");
	a_lane_quiet: assert property (
		(!cs_n_i && $stable(sclk_i)) [*8] |=> $stable(serial_out_lane0_o))
		else $error("lane moved without clock edge");
	a_sample_follows: assert property (
		$rose(conversion_start_i) && !converter_power_down_o |-> ##[3:7] conv_sample_o)
		else $error("no sample after start");
	a_conv_pd_edge: assert property (
		$changed(converter_power_down_o) |-> cs_n_i && $past(cs_n_i, 3))
		else $error("converter power changed outside select rise");
	a_ref_pd_edge: assert property (
		$changed(refbuf_power_down_o) |-> cs_n_i && $past(cs_n_i, 3))
		else $error("buffer power changed outside select rise");
	a_conv_wake: assert property (
		converter_powerup_start_o |-> $fell(converter_power_down_o))
		else $error("converter wake pulse without power-up");
	a_ref_wake: assert property (
		refbuf_powerup_start_o |-> $fell(refbuf_power_down_o))
		else $error("buffer wake pulse without power-up");
	c_frame: cover property ($rose(cs_n_i) ##6 !serial_out_lane0_oe_o);
	c_down: cover property ($rose(converter_power_down_o));
	c_wake: cover property (refbuf_powerup_start_o);
endmodule
bind adc_multidevice_serial adc_serial_props adc_serial_props_i (
	.clk_i(clk_i), .srst_i(srst_i), .conversion_start_i(conversion_start_i),
	.cs_n_i(cs_n_i), .sclk_i(sclk_i), .serial_out_lane0_o(serial_out_lane0_o),
	.serial_out_lane0_oe_o(serial_out_lane0_oe_o), .conv_sample_o(conv_sample_o),
	.converter_power_down_o(converter_power_down_o),
	.refbuf_power_down_o(refbuf_power_down_o),
	.converter_powerup_start_o(converter_powerup_start_o),
	.refbuf_powerup_start_o(refbuf_powerup_start_o)
);

// ==== dv/host_model.sv ====
// Host controller model: start, select, serial clock and word transfers.
`timescale 1ns/1ps
module host_model #(
	parameter PU_WAIT = 100
) (
	// Clock.
	input wire clk_i,
	// Return line from the last device.
	input wire bus_i,
	// Host pins.
	output reg conversion_start_o = 1'b0,
	output reg cs_n_o = 1'b1,
	output reg sclk_o = 1'b0,
	output reg sdi_o = 1'b0
);
	reg cpol = 1'b0;
	reg cpha = 1'b0;
	// Each level is held well past the device's pin synchroniser delay.
	task hold;
	begin
		repeat (8) @(negedge clk_i);
	end
	endtask
	task convert;
	begin
		conversion_start_o = 1'b1;
		hold;
		conversion_start_o = 1'b0;
		hold;
	end
	endtask
	task wake;
	begin
		repeat (PU_WAIT) @(negedge clk_i);
	end
	endtask
	task frame(input [43:0] w, input integer n, output [43:0] r);
		integer i;
	begin
		r = 44'h0;
		sclk_o = cpol;
		hold;
		// One select line only: no two devices sharing a return line are ever selected.
		cs_n_o = 1'b0;
		for (i = 0; i < n; i = i + 1)
		begin
			if (!cpha)
				sdi_o = (n - 1 - i < 44) ? w[n-1-i] : 1'b0;
			hold;
			if (!cpha)
				r = {r[42:0], bus_i};
			sclk_o = ~cpol;
			if (cpha)
				sdi_o = (n - 1 - i < 44) ? w[n-1-i] : 1'b0;
			hold;
			if (cpha)
				r = {r[42:0], bus_i};
			sclk_o = cpol;
		end
		hold;
		cs_n_o = 1'b1;
		sdi_o = ~sdi_o;
		hold;
	end
	endtask
endmodule

// ==== dv/tb_top.sv ====
// Bench: a two-device chain under the host model.
`timescale 1ns/1ps
`include "adc_chain_defines.vh"
module tb_top;
	localparam [17:0] DATA_A = 18'h2b3c1;
	localparam [17:0] DATA_B = 18'h15a5e;
	localparam [89:0] ADDRS = {10'h030, 10'h020, 10'h016, 10'h015, 10'h014, 10'h010,
		10'h00c, 10'h008, 10'h004};
	localparam [71:0] MASKS = {8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hdf, 8'h03, 8'h06};
	reg clk_i = 1'b0;
	reg srst_i = 1'b1;
	reg last_q = 1'b0;
	reg [17:0] data_a = DATA_A;
	reg [17:0] data_b = DATA_B;
	reg [43:0] r;
	integer errors = 0;
	integer checks_done = 0;
	integer n_smp = 0;
	integer n_up = 0;
	integer s;
	integer k;
	wire start_w, cs_n_w, sclk_w, host_w, mid_w, lane_w, oe_w, smp_a, smp_b;
	wire pd_c, pd_r, up_c, up_r;
	// A released lane shows the inverse of its last driven bit.
	wire bus_w = oe_w ? lane_w : ~last_q;
	always @(posedge clk_i)
	begin
		if (oe_w)
			last_q <= lane_w;
		// Pulses are unknown before the first reset edge, so count only out of reset.
		if (!srst_i)
		begin
			n_smp <= n_smp + smp_a + smp_b;
			n_up <= n_up + up_c + up_r;
		end
	end
	initial
	begin
		forever #4 clk_i = ~clk_i;
	end
	host_model host_model_i (
		.clk_i(clk_i), .bus_i(bus_w), .conversion_start_o(start_w),
		.cs_n_o(cs_n_w), .sclk_o(sclk_w), .sdi_o(host_w)
	);
	adc_multidevice_serial adc_multidevice_serial_i (
		.clk_i(clk_i), .srst_i(srst_i), .conversion_start_i(start_w), .cs_n_i(cs_n_w),
		.sclk_i(sclk_w), .sdi_i(host_w), .serial_out_lane0_o(mid_w),
		.serial_out_lane0_oe_o(), .conv_data_i(data_a), .conv_sample_o(smp_a),
		.converter_power_down_o(), .refbuf_power_down_o(),
		.converter_powerup_start_o(), .refbuf_powerup_start_o()
	);
	adc_multidevice_serial adc_multidevice_serial_last_i (
		.clk_i(clk_i), .srst_i(srst_i), .conversion_start_i(start_w), .cs_n_i(cs_n_w),
		.sclk_i(sclk_w), .sdi_i(mid_w), .serial_out_lane0_o(lane_w),
		.serial_out_lane0_oe_o(oe_w), .conv_data_i(data_b), .conv_sample_o(smp_b),
		.converter_power_down_o(pd_c), .refbuf_power_down_o(pd_r),
		.converter_powerup_start_o(up_c), .refbuf_powerup_start_o(up_r)
	);
	task check(input string what, input [43:0] exp, input [43:0] got);
	begin
		checks_done = checks_done + 1;
		if (got !== exp)
		begin
			errors = errors + 1;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	end
	endtask
	task xfer(input [21:0] w);
	begin
		host_model_i.frame({w, w}, 44, r);
	end
	endtask
	task t_modes;
	begin
		for (k = 1; k < 5; k = k + 1)
		begin
			xfer({`CMD_WRITE, 10'h008, 6'h0, k[1:0]});
			host_model_i.cpol = k[1];
			host_model_i.cpha = k[0];
			data_a = DATA_A ^ {15'h0, k[2:0]};
			data_b = DATA_B ^ {15'h0, k[2:0]};
			host_model_i.convert;
			xfer(22'h0);
			check("chain result", {data_b, 4'h0, data_a, 4'h0}, r);
		end
		check("sample count", 8, n_smp);
		$display("mode test done");
	end
	endtask
	task t_regs;
		reg [9:0] a;
	begin
		for (k = 0; k < 9; k = k + 1)
		begin
			a = ADDRS[k*10 +: 10];
			xfer({`CMD_WRITE, a, 8'hfd});
			host_model_i.cpol = (k == 1);
			host_model_i.cpha = (k == 1);
			xfer({`CMD_READ, a, 8'h00});
			xfer({`CMD_WRITE, a, 8'h00});
			host_model_i.cpol = 1'b0;
			host_model_i.cpha = 1'b0;
			check("register", {2{8'hfd & MASKS[k*8 +: 8], 14'h0}}, r);
		end
		$display("register test done");
	end
	endtask
	task t_power;
	begin
		xfer({`CMD_WRITE, 10'h004, 8'h06});
		check("power down", 2'b11, {pd_c, pd_r});
		s = n_smp;
		host_model_i.convert;
		check("sample while down", s, n_smp);
		s = n_up;
		xfer({`CMD_WRITE, 10'h004, 8'h00});
		check("power up", 2'b00, {pd_c, pd_r});
		check("wake pulses", s + 2, n_up);
		host_model_i.wake;
		s = n_smp;
		host_model_i.convert;
		check("sample after wake", s + 2, n_smp);
		$display("power test done");
	end
	endtask
	task t_short;
	begin
		host_model_i.frame({22'h0, `CMD_WRITE, 10'h014, 8'h77}, 21, r);
		xfer({`CMD_READ, 10'h014, 8'h00});
		xfer(22'h0);
		check("short frame", 44'h0, r);
		host_model_i.frame({`CMD_WRITE, 10'h015, 8'h5a, `CMD_WRITE, 10'h015, 8'h5a}, 46, r);
		xfer({`CMD_READ, 10'h015, 8'h00});
		xfer(22'h0);
		check("long frame", {2{8'h5a, 14'h0}}, r);
		$display("short frame test done");
	end
	endtask
	task stop_test;
	begin
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	end
	endtask
	initial
	begin
		repeat (2) @(negedge clk_i);
		srst_i = 1'b0;
		repeat (4) @(negedge clk_i);
		t_modes;
		t_regs;
		t_power;
		t_short;
		stop_test;
	end
	initial
	begin
		repeat (60000) @(posedge clk_i);
		errors = errors + 1;
		$display("[ERR] run length expected %0d seen %0d", 59999, 60000);
		stop_test;
	end
endmodule
